/* File: design/pcm_port_pkg.sv */
// Shared constants for the four-channel PCM serial port and its controller
package pcm_port_pkg;

	// Clocking
	localparam int CLK_HZ        = 25_000_000;
	localparam int MCLK_HZ       = 2_048_000;
	localparam int SYNC_HZ       = 8_000;
	localparam int MCLK_HALF_CYC = CLK_HZ / (2 * MCLK_HZ);
	localparam int FRAME_PERIODS = MCLK_HZ / SYNC_HZ;

	// Channels and slots
	localparam int NCH          = 4;
	localparam int SAMPLE_BITS  = 8;
	localparam int SLOT_SPACING = 64;
	localparam int MAX_SYNC_PER = 7;

	// Device timing, in microseconds and derived cycles
	localparam int PWRUP_HIZ_US   = 500;
	localparam int PWRUP_HIZ_CYC  = PWRUP_HIZ_US * (CLK_HZ / 1_000_000);
	localparam int CLK_LOSS_US    = 20;
	localparam int CLK_LOSS_CYC   = CLK_LOSS_US * (CLK_HZ / 1_000_000);

	// Controller sequencing gap, in master-clock periods
	localparam int SEQ_GAP_PERIODS = 16;

	// Reset values
	localparam logic [3:0] SLEEP_N_RST = 4'h0;
	localparam logic [3:0] SYNC_RST    = 4'h0;

	// Controller sequencing states
	typedef enum logic [4:0] {
		CS_OFF  = 5'h01,
		CS_CLK  = 5'h02,
		CS_RUN  = 5'h04,
		CS_STOP = 5'h08,
		CS_SPARE = 5'h10
	} ctl_state_t;

endpackage

/* File: design/pcm_link_if.sv */
// Serial highway between the PCM port and its frame controller
`timescale 1ns/1ps
`default_nettype none
interface pcm_link_if;
	logic       mclk;
	logic [3:0] slot_sync;
	logic [3:0] channel_sleep_n;
	logic       rx_serial_in;
	logic       tx_serial_out;
	logic       tx_serial_oe;
	wire        tx_line;

	// Released highway reads low, as through a pull-down
	assign tx_line = tx_serial_oe && tx_serial_out;

	modport dev (
		input  mclk,
		input  slot_sync,
		input  channel_sleep_n,
		input  rx_serial_in,
		output tx_serial_out,
		output tx_serial_oe
	);

	modport ctl (
		output mclk,
		output slot_sync,
		output channel_sleep_n,
		output rx_serial_in,
		input  tx_line,
		input  tx_serial_oe
	);
endinterface
`default_nettype wire

/* File: design/pcm_port_dev.sv */
// Device end: four-channel PCM slot engine with buffered receive words
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pcm_skid_buf #(
	parameter int W = 10
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Filling side
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	// Draining side
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	typedef struct packed {
		logic         ov;
		logic [W-1:0] od;
		logic         sv;
		logic [W-1:0] sd;
	} buf_st_t;

	buf_st_t st_r;
	buf_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (i_out_ready || !st_r.ov) begin
			if (st_r.sv) begin
				st_nxt.ov = 1'b1;
				st_nxt.od = st_r.sd;
				st_nxt.sv = 1'b0;
			end else begin
				st_nxt.ov = i_in_valid;
				st_nxt.od = i_in_data;
			end
		end else if (i_in_valid && !st_r.sv) begin
			st_nxt.sv = 1'b1;
			st_nxt.sd = i_in_data;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_in_ready  = !st_r.sv;
	assign o_out_valid = st_r.ov;
	assign o_out_data  = st_r.od;
endmodule

////////////////////////////////////////////////////////////////////////////////
module pcm_port_dev #(
	parameter int PWRUP_CYC = pcm_port_pkg::PWRUP_HIZ_CYC
) (
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	// Highway
	pcm_link_if.dev                  link,
	// Transmit samples, taken when the channel's sync is recognized
	input  wire logic [pcm_port_pkg::NCH-1:0][pcm_port_pkg::SAMPLE_BITS-1:0] i_tx_data,
	// Received samples
	output logic                     o_rx_valid,
	output logic [1:0]               o_rx_chan,
	output logic [pcm_port_pkg::SAMPLE_BITS-1:0] o_rx_data,
	input  wire logic                i_rx_ready,
	// Status
	output logic                     o_tx_live
);
	import pcm_port_pkg::*;

	localparam logic [13:0] PU_LAST = 14'(PWRUP_CYC - 1);
	localparam logic [9:0]  WD_LAST = 10'(CLK_LOSS_CYC - 1);
	localparam logic [3:0]  LAST_BIT = 4'(SAMPLE_BITS - 1);

	typedef struct packed {
		logic        mclk_d;
		logic        in_slot;
		logic        drive_ok;
		logic        recv_ok;
		logic [1:0]  chan;
		logic [3:0]  bitn;
		logic [7:0]  tx_sh;
		logic [7:0]  rx_sh;
		logic [3:0]  seen;
		logic        out;
		logic        oe;
		logic [13:0] pu_cnt;
		logic        pu_done;
		logic [9:0]  wd_cnt;
		logic        clk_lost;
		logic        pend;
		logic [9:0]  pend_word;
		logic        live;
	} dev_st_t;

	dev_st_t st_r;
	dev_st_t st_nxt;
	logic    buf_ready;
	logic [9:0] buf_word;

	always_comb begin
		logic rise;
		logic fall;
		logic found;
		rise   = 1'b0;
		fall   = 1'b0;
		found  = 1'b0;
		st_nxt = st_r;
		st_nxt.mclk_d = link.mclk;
		rise = link.mclk && !st_r.mclk_d;
		fall = !link.mclk && st_r.mclk_d;

		// Power-up float interval
		if (!st_r.pu_done) begin
			if (st_r.pu_cnt == PU_LAST) begin
				st_nxt.pu_done = 1'b1;
			end else begin
				st_nxt.pu_cnt = st_r.pu_cnt + 14'h0001;
			end
		end

		// Clock-loss watchdog
		if (rise || fall) begin
			st_nxt.wd_cnt   = '0;
			st_nxt.clk_lost = 1'b0;
		end else if (!st_r.clk_lost) begin
			if (st_r.wd_cnt == WD_LAST) begin
				st_nxt.clk_lost = 1'b1;
				st_nxt.in_slot  = 1'b0;
				st_nxt.oe       = 1'b0;
			end else begin
				st_nxt.wd_cnt = st_r.wd_cnt + 10'h001;
			end
		end

		if (st_r.pend && buf_ready) begin
			st_nxt.pend = 1'b0;
		end

		if (rise && st_r.in_slot) begin
			st_nxt.out   = st_r.tx_sh[7];
			st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
			st_nxt.oe    = st_r.drive_ok;
		end

		if (fall) begin
			if (st_r.in_slot) begin
				st_nxt.rx_sh = {st_r.rx_sh[6:0], link.rx_serial_in};
				st_nxt.bitn  = st_r.bitn + 4'h1;
				if (st_r.bitn == LAST_BIT) begin
					st_nxt.in_slot = 1'b0;
					st_nxt.oe      = 1'b0;
					if (st_r.recv_ok) begin
						// An undrained word is overwritten; slots are 64 periods apart
						st_nxt.pend      = 1'b1;
						st_nxt.pend_word = {st_r.chan, st_r.rx_sh[6:0], link.rx_serial_in};
					end
				end
			end
			for (int c = 0; c < NCH; c++) begin
				if (link.slot_sync[c] && !st_r.seen[c] && !found) begin
					found            = 1'b1;
					st_nxt.in_slot   = 1'b1;
					st_nxt.chan      = 2'(c);
					st_nxt.bitn      = '0;
					st_nxt.tx_sh     = i_tx_data[c];
					st_nxt.drive_ok  = link.channel_sleep_n[c] && st_r.pu_done;
					st_nxt.recv_ok   = link.channel_sleep_n[c];
				end
			end
			// A long sync is recognized only once
			st_nxt.seen = link.slot_sync;
		end
		st_nxt.live = st_nxt.pu_done && !st_nxt.clk_lost;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	pcm_skid_buf #(
		.W(10)
	) u_rx_buf (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (st_r.pend),
		.i_in_data   (st_r.pend_word),
		.o_in_ready  (buf_ready),
		.o_out_valid (o_rx_valid),
		.o_out_data  (buf_word),
		.i_out_ready (i_rx_ready)
	);

	assign o_rx_chan          = buf_word[9:8];
	assign o_rx_data          = buf_word[7:0];
	assign o_tx_live          = st_r.live;
	assign link.tx_serial_out = st_r.out;
	assign link.tx_serial_oe  = st_r.oe;
endmodule
`default_nettype wire

/* File: design/pcm_frame_ctl.sv */
// Controller end: master clock, slot syncs, sleep sequencing and slot data
`timescale 1ns/1ps
`default_nettype none
module pcm_frame_ctl (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Highway
	pcm_link_if.ctl         link,
	// Control
	input  wire logic       i_enable,
	input  wire logic [pcm_port_pkg::NCH-1:0] i_chan_awake,
	// Samples sent to the device, taken at each slot start
	input  wire logic [pcm_port_pkg::NCH-1:0][pcm_port_pkg::SAMPLE_BITS-1:0] i_down_data,
	// Samples received from the device
	output logic            o_up_valid,
	output logic [1:0]      o_up_chan,
	output logic [pcm_port_pkg::SAMPLE_BITS-1:0] o_up_data,
	// Status
	output logic            o_running
);
	import pcm_port_pkg::*;

	localparam logic [3:0] DIV_LAST = 4'(MCLK_HALF_CYC - 1);
	localparam logic [7:0] GAP_LAST = 8'(SEQ_GAP_PERIODS - 1);
	localparam logic [7:0] PER_LAST = 8'(FRAME_PERIODS - 1);
	localparam logic [5:0] BIT_LAST = 6'(SAMPLE_BITS);

	typedef struct packed {
		ctl_state_t  state;
		logic [3:0]  div;
		logic        mclk;
		logic [7:0]  gap;
		logic [7:0]  per;
		logic [3:0]  sync;
		logic [3:0]  sleep_n;
		logic        rxo;
		logic [7:0]  dn_sh;
		logic [7:0]  up_sh;
		logic        up_ok;
		logic        up_valid;
		logic [1:0]  up_chan;
		logic [7:0]  up_data;
		logic        running;
	} ctl_st_t;

	ctl_st_t st_r;
	ctl_st_t st_nxt;

	always_comb begin
		logic tick;
		logic rise_en;
		logic fall_en;
		logic [7:0] np;
		st_nxt          = st_r;
		st_nxt.up_valid = 1'b0;
		tick    = (st_r.state != CS_OFF) && (st_r.div == DIV_LAST);
		rise_en = tick && !st_r.mclk;
		fall_en = tick && st_r.mclk;
		np      = st_r.per + 8'h01;
		st_nxt.div = tick || (st_r.state == CS_OFF) ? 4'h0 : st_r.div + 4'h1;
		if (tick) begin
			st_nxt.mclk = !st_r.mclk;
		end
		case (st_r.state)
			CS_OFF: begin
				st_nxt.sleep_n = SLEEP_N_RST;
				st_nxt.sync    = SYNC_RST;
				if (i_enable) begin
					st_nxt.state = CS_CLK;
					st_nxt.gap   = '0;
				end
			end
			CS_CLK: begin
				if (rise_en) begin
					if (st_r.gap == GAP_LAST) begin
						st_nxt.state   = CS_RUN;
						st_nxt.sleep_n = i_chan_awake;
						st_nxt.per     = PER_LAST;
					end else begin
						st_nxt.gap = st_r.gap + 8'h01;
					end
				end
			end
			CS_RUN: begin
				st_nxt.sleep_n = i_chan_awake;
				if (rise_en) begin
					st_nxt.per  = np;
					// One-period sync every 64 periods, channels in order
					st_nxt.sync = (np[5:0] == 6'h00) ? (4'h1 << np[7:6]) : 4'h0;
					if (np[5:0] == 6'h00) begin
						st_nxt.dn_sh = i_down_data[np[7:6]];
						st_nxt.up_ok = 1'b1;
					end else if (np[5:0] <= BIT_LAST) begin
						st_nxt.rxo   = st_r.dn_sh[7];
						st_nxt.dn_sh = {st_r.dn_sh[6:0], 1'b0};
					end
					if (!i_enable && np == PER_LAST) begin
						st_nxt.state = CS_STOP;
						st_nxt.gap   = '0;
					end
				end
				if (fall_en && st_r.per[5:0] != 6'h00 && st_r.per[5:0] <= BIT_LAST) begin
					st_nxt.up_sh = {st_r.up_sh[6:0], link.tx_line};
					st_nxt.up_ok = st_r.up_ok && link.tx_serial_oe;
					if (st_r.per[5:0] == BIT_LAST) begin
						st_nxt.up_valid = st_r.up_ok && link.tx_serial_oe;
						st_nxt.up_chan  = st_r.per[7:6];
						st_nxt.up_data  = {st_r.up_sh[6:0], link.tx_line};
					end
				end
			end
			CS_STOP: begin
				st_nxt.sync    = SYNC_RST;
				st_nxt.sleep_n = SLEEP_N_RST;
				if (fall_en) begin
					if (st_r.gap == GAP_LAST) begin
						st_nxt.state = CS_OFF;
					end else begin
						st_nxt.gap = st_r.gap + 8'h01;
					end
				end
			end
			default: begin
				st_nxt.state = CS_OFF;
			end
		endcase
		st_nxt.running = (st_nxt.state == CS_RUN);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r       <= '0;
			st_r.state <= CS_OFF;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.mclk            = st_r.mclk;
	assign link.slot_sync       = st_r.sync;
	assign link.channel_sleep_n = st_r.sleep_n;
	assign link.rx_serial_in    = st_r.rxo;
	assign o_up_valid           = st_r.up_valid;
	assign o_up_chan            = st_r.up_chan;
	assign o_up_data            = st_r.up_data;
	assign o_running            = st_r.running;
endmodule
`default_nettype wire

/* File: tb/pcm_link_assertions.sv */
// Timing checks on the serial highway between port and controller
`timescale 1ns/1ps
`default_nettype none
module pcm_link_assertions #(
	parameter int PWRUP_CYC = 12500
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Highway
	input  wire logic       mclk,
	input  wire logic [3:0] slot_sync,
	input  wire logic [3:0] channel_sleep_n,
	input  wire logic       tx_serial_out,
	input  wire logic       tx_serial_oe
);
	logic [6:0]  len_r;
	logic [13:0] up_r;
	logic [9:0]  idle_r;
	logic [9:0]  gap_r;
	logic        mclk_r;
	logic        any_r;
	wire         any = |slot_sync;

	////////////////////////////////////////////////////////////////////////////
	// Gap saturates high so the first sync after reset is not judged
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			len_r  <= 7'h00;
			up_r   <= 14'h0000;
			idle_r <= 10'h000;
			gap_r  <= 10'h3FF;
			mclk_r <= 1'b0;
			any_r  <= 1'b0;
		end else begin
			len_r  <= tx_serial_oe ? len_r + 7'h01 : 7'h00;
			up_r   <= (&up_r) ? up_r : up_r + 14'h0001;
			idle_r <= (mclk != mclk_r) ? 10'h000 : idle_r + {9'h000, ~&idle_r};
			gap_r  <= (any && !any_r) ? 10'h001 : gap_r + {9'h000, ~&gap_r};
			mclk_r <= mclk;
			any_r  <= any;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_tx_enter;
		$rose(tx_serial_oe) |-> $past(mclk) && !$past(mclk, 2);
	endproperty
	a_tx_enter: assert property (p_tx_enter) else $error("drive began off a clock rise");
	property p_tx_exit;
		$fell(tx_serial_oe) |-> !$past(mclk) && $past(mclk, 2);
	endproperty
	a_tx_exit: assert property (p_tx_exit) else $error("release not after a clock fall");
	property p_tx_hold;
		tx_serial_oe && $past(tx_serial_oe) && !($past(mclk) && !$past(mclk, 2))
			|-> $stable(tx_serial_out);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("bit changed between rises");
	property p_tx_len;
		$fell(tx_serial_oe) |-> len_r == 7'h5A;
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("slot not eight bits long");
	property p_pwrup;
		tx_serial_oe |-> int'(up_r) + 2 >= PWRUP_CYC;
	endproperty
	a_pwrup: assert property (p_pwrup) else $error("drive during power-up float");
	property p_clk_loss;
		idle_r > 10'h1FE |-> !tx_serial_oe;
	endproperty
	a_clk_loss: assert property (p_clk_loss) else $error("drive with clock stopped");
	property p_slot_owner;
		$rose(tx_serial_oe) |-> |($past(slot_sync, 2) & channel_sleep_n);
	endproperty
	a_slot_owner: assert property (p_slot_owner) else $error("drive outside awake slot");
	property p_sync_edge;
		$changed(slot_sync) |-> $rose(mclk);
	endproperty
	a_sync_edge: assert property (p_sync_edge) else $error("sync not locked to clock");
	property p_sync_width;
		$rose(any) |-> ##11 any ##1 !any;
	endproperty
	a_sync_width: assert property (p_sync_width) else $error("sync not one period");
	property p_sync_gap;
		$rose(any) && gap_r < 10'h3FF |-> gap_r == 10'h300;
	endproperty
	a_sync_gap: assert property (p_sync_gap) else $error("sync spacing wrong");

	c_slot_done: cover property ($fell(tx_serial_oe));
	c_sync: cover property ($rose(any));
	c_clk_stop: cover property (idle_r > 10'h1FE);
endmodule
`default_nettype wire

/* File: tb/quad_channel_pcm_serial_port_test.sv */
// Self-checking bench for the PCM port and its frame controller
`timescale 1ns/1ps
`default_nettype none
module quad_channel_pcm_serial_port_test;
	import pcm_port_pkg::*;
	localparam int PWR = 4000;
	localparam int FRM = 3072;
	logic               i_clk, i_rst, i_rx_ready, i_enable;
	logic [3:0]         awake;
	logic [NCH-1:0][7:0] tx_d, dn_d;
	logic               rx_valid, up_valid, running, tx_live;
	logic [1:0]         rx_chan, up_chan;
	logic [7:0]         rx_data, up_data, tsh, rsh;
	int                 miscompares = 0, n_compared = 0, cyc = 0, n_up, first_up = 0;
	int                 rx_last, up_last, nb, wch;
	bit                 chk_en = 0, run = 0;

	pcm_link_if link ();
	pcm_port_dev #(.PWRUP_CYC(PWR)) pcm_port_dev_inst (.i_clk(i_clk), .i_rst(i_rst),
		.link(link), .i_tx_data(tx_d), .o_rx_valid(rx_valid), .o_rx_chan(rx_chan),
		.o_rx_data(rx_data), .i_rx_ready(i_rx_ready), .o_tx_live(tx_live));
	pcm_frame_ctl pcm_frame_ctl_inst (.i_clk(i_clk), .i_rst(i_rst), .link(link),
		.i_enable(i_enable), .i_chan_awake(awake), .i_down_data(dn_d),
		.o_up_valid(up_valid), .o_up_chan(up_chan), .o_up_data(up_data),
		.o_running(running));
	pcm_link_assertions #(.PWRUP_CYC(PWR)) pcm_link_assertions_inst (.i_clk(i_clk),
		.i_rst(i_rst), .mclk(link.mclk), .slot_sync(link.slot_sync),
		.channel_sleep_n(link.channel_sleep_n), .tx_serial_out(link.tx_serial_out),
		.tx_serial_oe(link.tx_serial_oe));

	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task print_verdict();
		$display("TB: %0d compares, %0d mismatches", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic int nxt(int c);
		int n;
		n = (c + 1) % 4;
		while (!awake[n]) n = (n + 1) % 4;
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Word streams on both user sides; order exposes lost words
	// Sampled mid-cycle so flop outputs are settled, not racing their edge
	always @(negedge i_clk) begin
		cyc++;
		if (up_valid && first_up == 0) first_up = cyc;
		if (up_valid && chk_en) begin
			n_up++;
			chk(up_data, tx_d[up_chan]);
			if (up_last >= 0) chk({6'h00, up_chan}, 8'(nxt(up_last)));
			up_last = up_chan;
		end
		if (rx_valid && i_rx_ready && chk_en) begin
			chk(rx_data, dn_d[rx_chan]);
			if (rx_last >= 0) chk({6'h00, rx_chan}, 8'(nxt(rx_last)));
			rx_last = rx_chan;
		end
		if (cyc > 40000) begin
			miscompares++;
			print_verdict();
		end
	end

	// Bits on the wire, sampled at each master-clock fall
	always @(negedge link.mclk) begin
		if (|link.slot_sync) begin
			for (int i = 3; i >= 0; i--) if (link.slot_sync[i]) wch = i;
			nb = 0;
			run = 1;
			if (chk_en) chk({7'h00, link.tx_serial_oe}, 8'h00);
		end else if (run) begin
			tsh = {tsh[6:0], link.tx_line};
			rsh = {rsh[6:0], link.rx_serial_in};
			nb++;
			if (nb == 8) begin
				run = 0;
				if (chk_en) chk(rsh, dn_d[wch]);
				if (chk_en && awake[wch]) chk(tsh, tx_d[wch]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	initial begin
		i_rst = 1'b1;
		i_enable = 1'b0;
		i_rx_ready = 1'b1;
		awake = 4'hF;
		tx_d = {8'hC3, 8'h81, 8'h5A, 8'h1E};
		dn_d = {8'h96, 8'h0F, 8'hE7, 8'h2D};
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk({3'h0, link.mclk, link.channel_sleep_n}, 8'h00);
		i_enable <= 1'b1;
		repeat (FRM) @(posedge i_clk);
		chk({7'h00, first_up == 0}, 8'h01);
		repeat (FRM) @(posedge i_clk);
		chk({7'h00, first_up >= PWR}, 8'h01);
		// Stall the receiver across two slot ends: both buffer entries fill
		rx_last = -1;
		up_last = -1;
		n_up = 0;
		chk_en <= 1'b1;
		i_rx_ready <= 1'b0;
		repeat (1800) @(posedge i_clk);
		i_rx_ready <= 1'b1;
		repeat (2 * FRM - 1800) @(posedge i_clk);
		chk_en <= 1'b0;
		@(posedge i_clk);
		chk(8'(n_up), 8'h08);
		chk({7'h00, tx_live}, 8'h01);
		// Channel two asleep, new samples both ways
		awake <= 4'hB;
		tx_d <= {8'h3C, 8'h7E, 8'hA5, 8'h01};
		dn_d <= {8'h80, 8'h69, 8'hF0, 8'h4B};
		repeat (FRM) @(posedge i_clk);
		rx_last = -1;
		up_last = -1;
		n_up = 0;
		chk_en <= 1'b1;
		repeat (2 * FRM) @(posedge i_clk);
		chk_en <= 1'b0;
		@(posedge i_clk);
		chk(8'(n_up), 8'h06);
		// Shutdown: syncs stop, sleep asserted, clock stops
		i_enable <= 1'b0;
		for (int k = 0; k < 4000 && running; k++) @(posedge i_clk);
		repeat (800) @(posedge i_clk);
		chk({2'h0, running, link.mclk, link.channel_sleep_n}, 8'h00);
		chk({6'h00, tx_live, link.tx_serial_oe}, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
